/* File: sim/dgc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dgc_top_bench
  import dgc_pkg::*;
;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, sys_cycles;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        left_on, right_on, mixer_on, uc_err, e;
  dgc_cfg_t    cfg, cfg_exp;
  int          n_fail, comparisons;

  dgc_top i_dut (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYSTEM_CLOCK_CYCLES(sys_cycles), .CFG(cfg), .PATH_LEFT_ON(left_on),
    .PATH_RIGHT_ON(right_on), .MIXER_ON(mixer_on), .UNDERCLOCK_ERR(uc_err));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // byte address is the register index times four
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 50)
      n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, idx, d, x, y);
  endtask : wr

  task automatic rdc(input string what, input logic [15:0] idx,
                     input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, idx, 32'h0000_0000, x, y);
    check(what, x, exp);
  endtask : rdc

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    sys_cycles = 16'h0100;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("limits", IDX_DECAY_LIMITS, 32'h0000_0133);
    rdc("slopes", IDX_GATE_SLOPES, 32'h0000_0018);
    rdc("knee", IDX_COMP_KNEE, 32'h0000_0000);
    rdc("gknee", IDX_GATE_KNEE, 32'h0000_0000);
    rdc("ctrl", IDX_PATH_CTRL, 32'h0000_0000);
    rdc("status", IDX_EFFECTS_STATUS, 32'h0000_0000);
    rdc("budget", IDX_CLOCK_BUDGET, 32'h0000_0100);
    // legal codes in every field, most at their top, undefined bits set as well
    wr(IDX_DECAY_LIMITS, 32'hFFFF_FF66);
    wr(IDX_GATE_SLOPES, 32'hFFFF_CEAC);
    wr(IDX_COMP_KNEE, 32'hFFFF_FF9E);
    wr(IDX_GATE_KNEE, 32'hFFFF_FFF1);
    wr(IDX_PATH_CTRL, 32'h0000_0120);
    rdc("limits", IDX_DECAY_LIMITS, 32'h0000_0166);
    rdc("slopes", IDX_GATE_SLOPES, 32'h0000_CEAC);
    rdc("knee", IDX_COMP_KNEE, 32'h0000_079E);
    rdc("gknee", IDX_GATE_KNEE, 32'h0000_03F1);
    rdc("ctrl", IDX_PATH_CTRL, 32'h0000_0120);
    cfg_exp = '{4'hB, 3'h1, 2'h2, 4'hC, 2'h3, 2'h2, 2'h2, 3'h5, 3'h4,
                6'h3C, 5'h1E, 5'h1F, 5'h11, 1'b1, 1'b1};
    check("cfg", 64'(cfg), 64'(cfg_exp));
    // reserved codes leave the held setting alone
    wr(IDX_DECAY_LIMITS, 32'h0000_0186);
    rdc("limits", IDX_DECAY_LIMITS, 32'h0000_0166);
    wr(IDX_GATE_SLOPES, 32'h0000_CEAD);
    rdc("slopes", IDX_GATE_SLOPES, 32'h0000_CEAC);
    wr(IDX_COMP_KNEE, 32'h0000_07BE);
    rdc("knee", IDX_COMP_KNEE, 32'h0000_079E);
    apb(1'b0, 16'h0E85, 32'h0000_0000, r, e);
    check("unmapped", {e, r}, 33'h0_0000_0000 | 33'h1_0000_0000);
    // budget 0x100 admits two paths, the mixer is refused
    wr(IDX_PATH_CTRL, 32'h0000_0123);
    repeat (4) @(posedge ref_clk);
    check("paths", {left_on, right_on, uc_err}, 3'b110);
    rdc("status", IDX_EFFECTS_STATUS, 32'h0000_0300);
    wr(IDX_PATH_CTRL, 32'h0000_0127);
    repeat (4) @(posedge ref_clk);
    check("refused", {left_on, right_on, mixer_on, uc_err}, 4'b1101);
    rdc("err", IDX_ERROR_STATUS, 32'h0000_0001);
    rdc("status", IDX_EFFECTS_STATUS, 32'h0000_0300);
    wr(IDX_PATH_CTRL, 32'h0000_0123);
    wr(IDX_ERROR_STATUS, 32'h0000_0001);
    rdc("err", IDX_ERROR_STATUS, 32'h0000_0000);
    // more cycles let the mixer in
    wr(IDX_CLOCK_BUDGET, 32'h0000_0180);
    sys_cycles <= 16'h0180;
    repeat (4) @(posedge ref_clk);
    wr(IDX_PATH_CTRL, 32'h0000_0127);
    repeat (4) @(posedge ref_clk);
    check("mixer", {mixer_on, uc_err}, 2'b10);
    rdc("err", IDX_ERROR_STATUS, 32'h0000_0002);
    // a budget drop stops nothing, but refuses a re-enable
    wr(IDX_CLOCK_BUDGET, 32'h0000_0080);
    wr(IDX_PATH_CTRL, 32'h0000_0125);
    wr(IDX_PATH_CTRL, 32'h0000_0127);
    repeat (4) @(posedge ref_clk);
    check("drop", {left_on, right_on, mixer_on, uc_err},
          4'b1011);
    rdc("status", IDX_EFFECTS_STATUS, 32'h0000_0100);
    summarize();
  end
endmodule : dgc_top_bench
`default_nettype wire

/* File: sim/dgc_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dgc_props
  import dgc_pkg::*;
(
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST,
  // register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // paths
  input wire logic [15:0] SYSTEM_CLOCK_CYCLES,
  input wire dgc_cfg_t    CFG,
  input wire logic        PATH_LEFT_ON,
  input wire logic        PATH_RIGHT_ON,
  input wire logic        MIXER_ON,
  input wire logic        UNDERCLOCK_ERR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // cycles since the last write access; saturates so it never wraps
  logic [3:0] since_wr;
  wire  [1:0] n_on = 2'(PATH_LEFT_ON) + 2'(PATH_RIGHT_ON) + 2'(MIXER_ON);

  always_ff @(posedge REF_CLK or posedge RST)
    if (RST)
      since_wr <= 4'h0;
    else if (PSEL && PENABLE && PWRITE)
      since_wr <= 4'h0;
    else if (since_wr != 4'hF)
      since_wr <= since_wr + 4'h1;

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  chk_ready_wait: assert property (s_setup ##1 s_wait |=> PREADY)
    else $error("answer not one wait state after access");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_slverr_ready: assert property (PSLVERR |-> PREADY)
    else $error("slave error outside an answer");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data outside an answer");
  chk_rdata_upper: assert property (PRDATA[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_cfg_cause: assert property ($changed(CFG) |-> since_wr <= 4'h2)
    else $error("configuration changed with no write");
  chk_path_keep: assert property (($fell(PATH_LEFT_ON) ||
    $fell(PATH_RIGHT_ON) || $fell(MIXER_ON)) |-> since_wr <= 4'h4)
    else $error("running path dropped with no write");
  chk_path_budget: assert property (n_on > $past(n_on) |->
    16'({n_on, 7'h00}) <= SYSTEM_CLOCK_CYCLES)
    else $error("path admitted beyond clock budget");
  chk_err_cause: assert property ($rose(UNDERCLOCK_ERR) |->
    n_on != 2'h3 && since_wr <= 4'h6)
    else $error("underclock error with no rejected enable");
  chk_err_sticky: assert property ($fell(UNDERCLOCK_ERR) |->
    since_wr <= 4'h3)
    else $error("underclock error cleared with no write");
endmodule : dgc_props

bind dgc_top dgc_props i_props (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SYSTEM_CLOCK_CYCLES(SYSTEM_CLOCK_CYCLES), .CFG(CFG),
  .PATH_LEFT_ON(PATH_LEFT_ON), .PATH_RIGHT_ON(PATH_RIGHT_ON),
  .MIXER_ON(MIXER_ON), .UNDERCLOCK_ERR(UNDERCLOCK_ERR));
`default_nettype wire

/* File: verilog/dgc_pkg.sv */
`default_nettype none
package dgc_pkg;

  // ---------------------------------------------------------------
  // register word indices (printed offsets are indices, byte address is x4)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_EFFECTS_STATUS  = 16'h0E01;
  localparam logic [15:0] IDX_PATH_CTRL       = 16'h0E80;
  localparam logic [15:0] IDX_DECAY_LIMITS    = 16'h0E81;
  localparam logic [15:0] IDX_GATE_SLOPES     = 16'h0E82;
  localparam logic [15:0] IDX_COMP_KNEE       = 16'h0E83;
  localparam logic [15:0] IDX_GATE_KNEE       = 16'h0E84;
  localparam logic [15:0] IDX_CLOCK_BUDGET    = 16'h0E90;
  localparam logic [15:0] IDX_ERROR_STATUS    = 16'h0E91;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_NOISE_GATE_ENABLE = 8;
  localparam int POS_GATE_KNEE_OP_ENA  = 5;
  localparam int POS_PATH_LEFT_ENA     = 0;
  localparam int POS_PATH_RIGHT_ENA    = 1;
  localparam int POS_PATH_MIXER_ENA    = 2;
  localparam int POS_STS_LEFT          = 8;
  localparam int POS_STS_RIGHT         = 9;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_DECAY_RATE   = 4'h9;
  localparam logic [2:0] RST_MIN_ATTEN    = 3'h4;
  localparam logic [1:0] RST_MAX_BOOST    = 2'h3;
  localparam logic [3:0] RST_GATE_MIN     = 4'h0;
  localparam logic [1:0] RST_GATE_EXP     = 2'h0;
  localparam logic [1:0] RST_QR_THR       = 2'h0;
  localparam logic [1:0] RST_QR_DECAY     = 2'h0;
  localparam logic [2:0] RST_UPPER_SLOPE  = 3'h3;
  localparam logic [2:0] RST_LOWER_SLOPE  = 3'h0;
  localparam logic [5:0] RST_KNEE_IN      = 6'h00;
  localparam logic [4:0] RST_KNEE_OUT     = 5'h00;
  localparam logic [4:0] RST_GKNEE_IN     = 5'h00;
  localparam logic [4:0] RST_GKNEE_OUT    = 5'h00;
  localparam logic [15:0] RST_CLOCK_BUDGET = 16'h0100;

  // ---------------------------------------------------------------
  // highest legal codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MAX_DECAY_RATE  = 4'hB;
  localparam logic [2:0] MAX_MIN_ATTEN   = 3'h4;
  localparam logic [3:0] MAX_GATE_MIN    = 4'hC;
  localparam logic [1:0] MAX_QR_DECAY    = 2'h2;
  localparam logic [2:0] MAX_UPPER_SLOPE = 3'h5;
  localparam logic [2:0] MAX_LOWER_SLOPE = 3'h4;
  localparam logic [5:0] MAX_KNEE_IN     = 6'h3C;
  localparam logic [4:0] MAX_KNEE_OUT    = 5'h1E;

  // cycles each path costs out of the per-sample clock budget
  localparam logic [15:0] PATH_CYCLE_COST = 16'h0080;

  typedef struct packed {
    logic [3:0] decay_rate;
    logic [2:0] min_atten;
    logic [1:0] max_boost;
    logic [3:0] gate_min;
    logic [1:0] gate_exp;
    logic [1:0] qr_thr;
    logic [1:0] qr_decay;
    logic [2:0] upper_slope;
    logic [2:0] lower_slope;
    logic [5:0] knee_in;
    logic [4:0] knee_out;
    logic [4:0] gknee_in;
    logic [4:0] gknee_out;
    logic       gate_ena;
    logic       gknee_op_ena;
  } dgc_cfg_t;

endpackage : dgc_pkg
`default_nettype wire

/* File: verilog/dgc_top.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - decay rate bits 8:5, reset 1001, codes above 1011 reserved
// - minimum attenuation bits 4:2, reset 100, codes above 100 reserved
// - maximum boost bits 1:0, reset 11
// - gate minimum gain bits 15:12, reset 0000, above 1100 reserved
// - gate expansion slope bits 11:10, reset 00
// - quick release threshold bits 9:8, reset 00
// - quick release decay bits 7:6, reset 00, code 11 reserved
// - upper compressor slope bits 5:3, reset 011, 110/111 reserved
// - lower compressor slope bits 2:0, reset 000, above 100 reserved
// - knee input level bits 10:5, reset 0, above 111100 reserved
// - knee output level bits 4:0, reset 0, 11111 reserved
// - gate knee input bits 9:5, effective only with gate enabled
// - gate knee output bits 4:0, effective only with its enable set
// - path enable fails when clock cycles are insufficient
// - failed enable leaves running paths untouched
// - rejected enable raises underclock error, routed to pin output
// - effects status reads back paths actually enabled
// - mixer status bit reads back actual enable state
// - noise gate enable bit 8, reset 0
// - gate knee output enable bit 5, reset 0
// - status bit 4 left path, bit 5 right path
module dgc_top
  import dgc_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // system clock budget from the clocking block, cycles per sample
  input  wire logic [15:0]       SYSTEM_CLOCK_CYCLES,
  // configuration to the gain datapath
  output dgc_cfg_t               CFG,
  output logic                   PATH_LEFT_ON,
  output logic                   PATH_RIGHT_ON,
  output logic                   MIXER_ON,
  // underclock error level, for gpio and interrupt routing
  output logic                   UNDERCLOCK_ERR
);

  // ---------------------------------------------------------------
  // synchronise the external budget
  // ---------------------------------------------------------------
  // the word is taken only once two synced samples agree, so a change
  // caught mid-flight never yields a mix of old and new bits
  logic [15:0] budget_meta;
  logic [15:0] budget_sync;
  logic [15:0] budget_prev;
  logic [15:0] budget_stable;
  wire         budget_settled = (budget_sync == budget_prev);

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      budget_meta   <= '0;
      budget_sync   <= '0;
      budget_prev   <= '0;
      budget_stable <= '0;
    end
    else
    begin
      budget_meta <= SYSTEM_CLOCK_CYCLES;
      budget_sync <= budget_meta;
      budget_prev <= budget_sync;
      if (budget_settled)
        budget_stable <= budget_sync;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire         access   = PSEL & PENABLE;
  wire [ADDR_W-3:0] word_idx = PADDR[ADDR_W-1:2];
  wire         aligned  = (PADDR[1:0] == 2'b00);
  wire         hit_sts  = aligned && (word_idx == IDX_EFFECTS_STATUS[ADDR_W-3:0]);
  wire         hit_ctl  = aligned && (word_idx == IDX_PATH_CTRL[ADDR_W-3:0]);
  wire         hit_dcy  = aligned && (word_idx == IDX_DECAY_LIMITS[ADDR_W-3:0]);
  wire         hit_gsl  = aligned && (word_idx == IDX_GATE_SLOPES[ADDR_W-3:0]);
  wire         hit_knee = aligned && (word_idx == IDX_COMP_KNEE[ADDR_W-3:0]);
  wire         hit_gkn  = aligned && (word_idx == IDX_GATE_KNEE[ADDR_W-3:0]);
  wire         hit_bud  = aligned && (word_idx == IDX_CLOCK_BUDGET[ADDR_W-3:0]);
  wire         hit_err  = aligned && (word_idx == IDX_ERROR_STATUS[ADDR_W-3:0]);
  wire         mapped   = hit_sts | hit_ctl | hit_dcy | hit_gsl | hit_knee
                        | hit_gkn | hit_bud | hit_err;
  // writes land only at the edge where the master sees pready
  wire         wr       = access & PREADY & PWRITE & mapped;
  wire         wr_lo    = wr & PSTRB[0];
  wire         wr_hi    = wr & PSTRB[1];
  wire [15:0]  wd       = PWDATA[15:0];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  dgc_cfg_t    cfg;
  logic [15:0] clock_budget;
  logic        req_left;
  logic        req_right;
  logic        req_mixer;
  logic        err_sticky;

  // reserved codes are dropped so the previous valid value stays
  wire ok_dcy   = (wd[8:5] <= MAX_DECAY_RATE);
  wire ok_minat = (wd[4:2] <= MAX_MIN_ATTEN);
  wire ok_gmin  = (wd[15:12] <= MAX_GATE_MIN);
  wire ok_qrd   = (wd[7:6] <= MAX_QR_DECAY);
  wire ok_up    = (wd[5:3] <= MAX_UPPER_SLOPE);
  wire ok_lo    = (wd[2:0] <= MAX_LOWER_SLOPE);
  wire ok_kin   = (wd[10:5] <= MAX_KNEE_IN);
  wire ok_kout  = (wd[4:0] <= MAX_KNEE_OUT);

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg.decay_rate   <= RST_DECAY_RATE;
      cfg.min_atten    <= RST_MIN_ATTEN;
      cfg.max_boost    <= RST_MAX_BOOST;
      cfg.gate_min     <= RST_GATE_MIN;
      cfg.gate_exp     <= RST_GATE_EXP;
      cfg.qr_thr       <= RST_QR_THR;
      cfg.qr_decay     <= RST_QR_DECAY;
      cfg.upper_slope  <= RST_UPPER_SLOPE;
      cfg.lower_slope  <= RST_LOWER_SLOPE;
      cfg.knee_in      <= RST_KNEE_IN;
      cfg.knee_out     <= RST_KNEE_OUT;
      cfg.gknee_in     <= RST_GKNEE_IN;
      cfg.gknee_out    <= RST_GKNEE_OUT;
      cfg.gate_ena     <= 1'b0;
      cfg.gknee_op_ena <= 1'b0;
      clock_budget     <= RST_CLOCK_BUDGET;
      req_left         <= 1'b0;
      req_right        <= 1'b0;
      req_mixer        <= 1'b0;
    end
    else
    begin
      if (hit_dcy && wr_hi && ok_dcy)
        cfg.decay_rate[3] <= wd[8];
      if (hit_dcy && wr_lo && ok_dcy)
        cfg.decay_rate[2:0] <= wd[7:5];
      if (hit_dcy && wr_lo && ok_minat)
        cfg.min_atten <= wd[4:2];
      if (hit_dcy && wr_lo)
        cfg.max_boost <= wd[1:0];
      if (hit_gsl && wr_hi && ok_gmin)
        cfg.gate_min <= wd[15:12];
      if (hit_gsl && wr_hi)
      begin
        cfg.gate_exp <= wd[11:10];
        cfg.qr_thr   <= wd[9:8];
      end
      if (hit_gsl && wr_lo && ok_qrd)
        cfg.qr_decay <= wd[7:6];
      if (hit_gsl && wr_lo && ok_up)
        cfg.upper_slope <= wd[5:3];
      if (hit_gsl && wr_lo && ok_lo)
        cfg.lower_slope <= wd[2:0];
      if (hit_knee && wr_hi && wr_lo && ok_kin)
        cfg.knee_in <= wd[10:5];
      if (hit_knee && wr_lo && ok_kout)
        cfg.knee_out <= wd[4:0];
      if (hit_gkn && wr_hi && wr_lo)
        cfg.gknee_in <= wd[9:5];
      if (hit_gkn && wr_lo)
        cfg.gknee_out <= wd[4:0];
      if (hit_ctl && wr_hi)
        cfg.gate_ena <= wd[POS_NOISE_GATE_ENABLE];
      if (hit_ctl && wr_lo)
      begin
        cfg.gknee_op_ena <= wd[POS_GATE_KNEE_OP_ENA];
        req_left  <= wd[POS_PATH_LEFT_ENA];
        req_right <= wd[POS_PATH_RIGHT_ENA];
        req_mixer <= wd[POS_PATH_MIXER_ENA];
      end
      if (hit_bud && wr_hi && wr_lo)
        clock_budget <= wd;
    end
  end

  // ---------------------------------------------------------------
  // clock budget admission
  // ---------------------------------------------------------------
  // a path is admitted only while running paths plus it fit the budget;
  // one path is admitted per cycle so the sum never overshoots
  logic        on_left;
  logic        on_right;
  logic        on_mixer;
  wire  [1:0]  n_on     = 2'(on_left) + 2'(on_right) + 2'(on_mixer);
  wire  [17:0] used     = 18'(n_on) * 18'(PATH_CYCLE_COST);
  wire  [17:0] need     = used + 18'(PATH_CYCLE_COST);
  wire  [15:0] avail    = (budget_stable < clock_budget) ? budget_stable
                                                         : clock_budget;
  wire         fits     = (need <= 18'(avail));
  wire         want_l   = req_left  & ~on_left;
  wire         want_r   = req_right & ~on_right & ~want_l;
  wire         want_m   = req_mixer & ~on_mixer & ~want_l & ~want_r;
  wire         want_any = want_l | want_r | want_m;
  wire         reject   = want_any & ~fits;
  wire         err_clr  = hit_err & wr_lo & wd[0];

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      on_left    <= 1'b0;
      on_right   <= 1'b0;
      on_mixer   <= 1'b0;
      err_sticky <= 1'b0;
    end
    else
    begin
      // a running path stops only when software drops its request
      on_left  <= req_left  & (on_left  | (want_l & fits));
      on_right <= req_right & (on_right | (want_r & fits));
      on_mixer <= req_mixer & (on_mixer | (want_m & fits));
      // set wins over a clear in the same cycle
      err_sticky <= reject | (err_sticky & ~err_clr);
    end
  end

  // ---------------------------------------------------------------
  // read mux and outputs
  // ---------------------------------------------------------------
  logic [15:0] rd;
  // the status field starts at bit 4, so its path bits sit at 8 and 9
  wire  [15:0] rd_sts = (16'(on_left) << POS_STS_LEFT)
                      | (16'(on_right) << POS_STS_RIGHT);
  wire  [15:0] rd_ctl = {7'h00, cfg.gate_ena, 2'h0, cfg.gknee_op_ena,
                         2'h0, req_mixer, req_right, req_left};
  wire  [15:0] rd_dcy = {7'h00, cfg.decay_rate, cfg.min_atten,
                         cfg.max_boost};
  wire  [15:0] rd_gsl = {cfg.gate_min, cfg.gate_exp, cfg.qr_thr,
                         cfg.qr_decay, cfg.upper_slope, cfg.lower_slope};
  wire  [15:0] rd_kn  = {5'h00, cfg.knee_in, cfg.knee_out};
  wire  [15:0] rd_gk  = {6'h00, cfg.gknee_in, cfg.gknee_out};
  wire  [15:0] rd_err = {14'h0000, on_mixer, err_sticky};

  always_comb
  begin
    rd = 16'h0000;
    if (hit_sts)  rd = rd_sts;
    if (hit_ctl)  rd = rd_ctl;
    if (hit_dcy)  rd = rd_dcy;
    if (hit_gsl)  rd = rd_gsl;
    if (hit_knee) rd = rd_kn;
    if (hit_gkn)  rd = rd_gk;
    if (hit_bud)  rd = clock_budget;
    if (hit_err)  rd = rd_err;
  end

  // pready is registered: one wait state, then the answer
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA         <= '0;
      PREADY         <= 1'b0;
      PSLVERR        <= 1'b0;
      CFG            <= '0;
      PATH_LEFT_ON   <= 1'b0;
      PATH_RIGHT_ON  <= 1'b0;
      MIXER_ON       <= 1'b0;
      UNDERCLOCK_ERR <= 1'b0;
    end
    else
    begin
      PREADY         <= access & ~PREADY;
      PSLVERR        <= access & ~PREADY & ~mapped;
      PRDATA         <= (access & ~PREADY & ~PWRITE) ? {16'h0000, rd}
                                                     : 32'h0000_0000;
      CFG            <= cfg;
      PATH_LEFT_ON   <= on_left;
      PATH_RIGHT_ON  <= on_right;
      MIXER_ON       <= on_mixer;
      UNDERCLOCK_ERR <= err_sticky;
    end
  end

endmodule : dgc_top
`default_nettype wire
